/* logic/adcctl_pkg.sv */
// adcctl_pkg: register map, field positions, reset values and timing constants
// of the converter control and result-register block.
// assumes the die-link slave port presents byte addresses of the converter space.
package adcctl_pkg;

    // register byte addresses
    localparam logic [31:0] ADCCTL_CONFIG_ADDR  = 32'h4008_2174;
    localparam logic [31:0] ADCCTL_RESULT_BASE  = 32'h4008_6000;
    localparam logic [31:0] ADCCTL_RESULT_LAST  = 32'h4008_606c;
    localparam logic [31:0] ADCCTL_RESULT_STEP  = 32'h0000_0004;
    localparam logic [31:0] ADCCTL_CHSEL_ADDR   = 32'h4008_6080;

    // channel count
    localparam int          ADCCTL_NUM_CH       = 28;

    // config fields
    localparam int          ADCCTL_CFG_SWRST    = 10;
    localparam int          ADCCTL_CFG_PUP      = 9;
    localparam int          ADCCTL_CFG_REFB     = 7;
    localparam int          ADCCTL_CFG_RESTART  = 6;
    localparam int          ADCCTL_CFG_SEQDMA   = 4;
    localparam int          ADCCTL_CFG_CNVDMA   = 3;
    localparam logic [15:0] ADCCTL_CFG_RESET    = 16'h0280;
    localparam logic [15:0] ADCCTL_CFG_RMASK    = 16'h029f;

    // conversion type codes
    localparam logic [2:0]  ADCCTL_CT_IDLE      = 3'h0;
    localparam logic [2:0]  ADCCTL_CT_PIN       = 3'h1;
    localparam logic [2:0]  ADCCTL_CT_SINGLE    = 3'h2;
    localparam logic [2:0]  ADCCTL_CT_CONT      = 3'h3;
    localparam logic [2:0]  ADCCTL_CT_LOGIC     = 3'h4;

    // channel select fields
    localparam logic [15:0] ADCCTL_CHSEL_RESET  = 16'h111f;
    localparam logic [15:0] ADCCTL_CHSEL_RMASK  = 16'h1f1f;
    localparam logic [4:0]  ADCCTL_NEG_MAXCODE  = 5'h13;

    // result word layout
    localparam int          ADCCTL_RES_VALID    = 3;
    localparam int          ADCCTL_RES_OLD      = 2;
    localparam int          ADCCTL_RES_DLSB     = 12;

    // update window timing
    localparam int          ADCCTL_CLK_MHZ      = 25;
    localparam int          ADCCTL_WIN_NS       = 100;
    localparam int          ADCCTL_WIN_CYC      = (ADCCTL_WIN_NS * ADCCTL_CLK_MHZ + 999) / 1000;

endpackage

/* logic/adcctl_top.sv */
// adcctl_top: configuration, channel select and 28 result registers of a
// successive-approximation converter, reached by single-cycle register port.
// assumes the analog core and sequencer sit outside on the same clock and
// hand finished samples in as a one-cycle pulse with channel and value.
//
// How it works
// - writing restart pulses analog reset output
// - sequencer dma requests gated by bit four
// - single conversion dma requests gated by three
// - conversion type decoded into five trigger modes
// - each finished sample for channels 0 to 27 lands in its channel word
// - result update window lasts three cycles, 120 ns at 25 MHz
// - reads during update window return all zero
// - blanking applies identically in every conversion mode
// - sample in 27:12, sign above, zeros in 11:4 and 1:0
// - bit three reads one when sample valid
// - bit two set once sample has been read
// - negative select resets 0x11, codes above 0x13 reserved
// - channel select steers only non-sequenced conversions
// - positive select resets 0x1f in low bits
`timescale 1ns/1ns
`default_nettype none

module adcctl_top
    import adcctl_pkg::*;
#(
    parameter int NUM_CH = adcctl_pkg::ADCCTL_NUM_CH
) (
    input  wire logic        clock,
    input  wire logic        nrst,
    // die-link register port
    input  wire logic        reg_req,
    input  wire logic        reg_write,
    input  wire logic [31:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    output logic [31:0]      reg_rdata,
    output logic             reg_ack,
    output logic             reg_err,
    // finished sample from the converter core
    input  wire logic        sample_done,
    input  wire logic        sample_from_seq,
    input  wire logic [4:0]  sample_channel,
    input  wire logic [15:0] sample_value,
    // control toward the analog core and sequencer
    output logic             converter_power_on,
    output logic             ref_buffer_power_on,
    output logic             analog_restart,
    output logic             trig_idle,
    output logic             trig_pin,
    output logic             trig_single,
    output logic             trig_continuous,
    output logic             trig_logic_array,
    output logic [4:0]       positive_input_select,
    output logic [4:0]       negative_input_select,
    output logic             use_channel_select,
    output logic             sequencer_dma_request_enable_req,
    output logic             single_dma_req
);
    import adcctl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [15:0]             cfg;
        logic [15:0]             chsel;
        logic                    restart;
        logic                    sequencer_dma_request_enable;
        logic                    single_dma_request_enable;
        logic [31:0]             rdata;
        logic                    ack;
        logic                    err;
        logic [NUM_CH-1:0]       valid;
        logic [NUM_CH-1:0]       old;
        logic [NUM_CH-1:0][15:0] data;
        logic [NUM_CH-1:0][1:0]  win;
    } adcctl_state_type;

    adcctl_state_type st_r;
    adcctl_state_type st_nxt;

    logic        in_result;
    logic [31:0] roff;
    logic [4:0]  ridx;
    logic [31:0] rword;
    logic [15:0] cfg_w;

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    assign roff      = reg_addr - ADCCTL_RESULT_BASE;
    assign ridx      = roff[6:2];
    assign in_result = (reg_addr >= ADCCTL_RESULT_BASE) && (reg_addr <= ADCCTL_RESULT_LAST)
                       && (roff[1:0] == 2'h0);

    // layout of the addressed result word, zero while its update window runs
    always_comb begin
        rword = 32'h0000_0000;
        if (in_result && (st_r.win[ridx] == 2'h0)) begin
            rword = {{4{st_r.data[ridx][15]}}, st_r.data[ridx], 8'h00,
                     st_r.valid[ridx], st_r.old[ridx], 2'h0};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        st_nxt         = st_r;
        st_nxt.ack     = reg_req;
        st_nxt.err     = 1'b0;
        st_nxt.rdata   = 32'h0000_0000;
        st_nxt.restart = 1'b0;
        cfg_w          = reg_wdata[15:0] & ADCCTL_CFG_RMASK;

        // update windows count down; a new sample reloads its own
        for (int i = 0; i < NUM_CH; i++) begin
            if (st_r.win[i] != 2'h0) begin
                st_nxt.win[i] = st_r.win[i] - 2'h1;
            end
        end

        // sample lands and opens the blanking window
        if (sample_done && (sample_channel < 5'(NUM_CH))) begin
            st_nxt.data[sample_channel]  = sample_value;
            st_nxt.valid[sample_channel] = 1'b1;
            st_nxt.old[sample_channel]   = 1'b0;
            st_nxt.win[sample_channel]   = 2'(ADCCTL_WIN_CYC);
        end

        // dma requests raised with the sample, gated per source
        st_nxt.sequencer_dma_request_enable = sample_done && sample_from_seq && st_r.cfg[ADCCTL_CFG_SEQDMA];
        st_nxt.single_dma_request_enable = sample_done && !sample_from_seq && st_r.cfg[ADCCTL_CFG_CNVDMA];

        if (reg_req) begin
            if (reg_addr == ADCCTL_CONFIG_ADDR) begin
                if (reg_write) begin
                    if (reg_wdata[ADCCTL_CFG_SWRST]) begin
                        st_nxt.cfg   = ADCCTL_CFG_RESET;
                        st_nxt.chsel = ADCCTL_CHSEL_RESET;
                    end else begin
                        st_nxt.cfg = cfg_w;
                    end
                    st_nxt.restart = reg_wdata[ADCCTL_CFG_RESTART];
                end else begin
                    st_nxt.rdata = {16'h0000, st_r.cfg}; // write-only bits never stored
                end
            end else if (reg_addr == ADCCTL_CHSEL_ADDR) begin
                if (reg_write) begin
                    st_nxt.chsel = reg_wdata[15:0] & ADCCTL_CHSEL_RMASK;
                end else begin
                    st_nxt.rdata = {16'h0000, st_r.chsel};
                end
            end else if (in_result) begin
                if (!reg_write) begin
                    st_nxt.rdata = rword;
                    // only a read that saw a settled sample marks it as taken
                    if ((st_r.win[ridx] == 2'h0) && st_r.valid[ridx]
                        && !(sample_done && (sample_channel == ridx))) begin
                        st_nxt.old[ridx] = 1'b1;
                    end
                end
            end else begin
                st_nxt.err = 1'b1; // unmapped address
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clock) begin
        if (!nrst) begin
            st_r       <= '0;
            st_r.cfg   <= ADCCTL_CFG_RESET;
            st_r.chsel <= ADCCTL_CHSEL_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign reg_rdata             = st_r.rdata;
    assign reg_ack               = st_r.ack;
    assign reg_err               = st_r.err;
    assign converter_power_on    = st_r.cfg[ADCCTL_CFG_PUP];
    assign ref_buffer_power_on   = st_r.cfg[ADCCTL_CFG_REFB];
    assign analog_restart        = st_r.restart;
    assign sequencer_dma_request_enable_req           = st_r.sequencer_dma_request_enable;
    assign single_dma_req        = st_r.single_dma_request_enable;

    // conversion type decode; codes above the logic-array trigger act idle
    assign trig_pin              = (st_r.cfg[2:0] == ADCCTL_CT_PIN);
    assign trig_single           = (st_r.cfg[2:0] == ADCCTL_CT_SINGLE);
    assign trig_continuous       = (st_r.cfg[2:0] == ADCCTL_CT_CONT);
    assign trig_logic_array      = (st_r.cfg[2:0] == ADCCTL_CT_LOGIC);
    assign trig_idle             = !(trig_pin || trig_single || trig_continuous
                                     || trig_logic_array);

    // the select register drives inputs; the core ignores it under the sequencer
    assign positive_input_select = st_r.chsel[4:0];
    assign negative_input_select = st_r.chsel[12:8];
    assign use_channel_select    = !sample_from_seq;

endmodule

`default_nettype wire

/* tb/adcctl_props.sv */
// adcctl_props: port checks of the register block
// assumes one clock and synchronous active-low nrst
`timescale 1ns/1ns
`default_nettype none
module adcctl_props
    import adcctl_pkg::*;
(
    input wire logic        clock,
    input wire logic        nrst,
    input wire logic        reg_req,
    input wire logic        reg_write,
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_rdata,
    input wire logic        reg_ack,
    input wire logic        sample_done,
    input wire logic        sample_from_seq,
    input wire logic [4:0]  sample_channel,
    input wire logic        use_channel_select,
    input wire logic        sequencer_dma_request_enable_req,
    input wire logic        single_dma_req
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // read of one of the 28 result words
    wire logic rd_res = reg_req && !reg_write && reg_addr >= ADCCTL_RESULT_BASE
        && reg_addr <= ADCCTL_RESULT_LAST;
    ////////
    a_ack_next: assert property (reg_req |=> reg_ack) else $error("no ack");
    a_ack_once: assert property (reg_ack |-> $past(reg_req)) else $error("stray ack");
    a_sequencer_dma_request_enable: assert property (sequencer_dma_request_enable_req |-> $past(sample_done && sample_from_seq))
        else $error("stray sequencer_dma_request_enable");
    a_single_dma_request_enable: assert property (
        single_dma_req |-> $past(sample_done && !sample_from_seq)) else $error("stray dma");
    a_read_blank: assert property (
        sample_done && sample_channel < 28 ##1 rd_res && reg_addr[6:2] == $past(sample_channel)
        |=> reg_rdata == 32'h0) else $error("not blanked");
    a_word_layout: assert property (
        $past(rd_res) |-> reg_rdata[11:4] == 8'h00 && reg_rdata[1:0] == 2'h0
        && reg_rdata[31:28] == {4{reg_rdata[27]}}) else $error("bad layout");
    a_invalid_zero: assert property (
        $past(rd_res) && !reg_rdata[3] |-> reg_rdata == 32'h0) else $error("not zero");
    a_input_steer: assert property (
        use_channel_select == !sample_from_seq) else $error("bad steer");
    cover property (sequencer_dma_request_enable_req);
    cover property (single_dma_req);
    cover property (sample_done ##1 rd_res);
endmodule
bind adcctl_top adcctl_props adcctl_props_inst (.*);
`default_nettype wire

/* tb/adcctl_host.sv */
// adcctl_host: processor end of the die link, one access per call
// assumes the block acks on the edge after the request
`timescale 1ns/1ns
`default_nettype none
module adcctl_host (
    input  wire logic        clock,
    output logic             reg_req,
    output logic             reg_write,
    output logic [31:0]      reg_addr,
    output logic [31:0]      reg_wdata,
    input  wire logic [31:0] reg_rdata,
    input  wire logic        reg_ack,
    input  wire logic        reg_err
);
    initial {reg_req, reg_write, reg_addr, reg_wdata} = '0;
    // released lines carry inverted values so stale data cannot match
    task automatic xfer(input logic w, input logic [31:0] a, d,
                        output logic [31:0] q, output logic e);
        int n = 0;
        @(posedge clock) #1;
        {reg_req, reg_write, reg_addr, reg_wdata} = {1'b1, w, a, d};
        @(posedge clock) #1;
        {reg_req, reg_addr, reg_wdata} = {1'b0, ~a, ~d};
        while (reg_ack !== 1'b1 && n < 4) begin
            @(posedge clock) #1;
            n++;
        end
        if (n == 4) adcctl_bench.test_done(1);
        q = reg_rdata;
        e = reg_err;
    endtask
endmodule
`default_nettype wire

/* tb/adcctl_bench.sv */
// adcctl_bench: random and corner tests of the register block
// assumes adcctl_host drives the register port
`timescale 1ns/1ns
`default_nettype none
module adcctl_bench;
    import adcctl_pkg::*;
    logic        clock = 1'b0;
    logic        nrst = 1'b0;
    logic        sample_done = 1'b0;
    logic        sample_from_seq = 1'b0;
    logic [4:0]  sample_channel = 5'h00;
    logic [15:0] sample_value = 16'h0000;
    logic        reg_req, reg_write, reg_ack, reg_err, e, converter_power_on;
    logic        ref_buffer_power_on, analog_restart, use_channel_select;
    logic        trig_idle, trig_pin, trig_single, trig_continuous, trig_logic_array;
    logic        sequencer_dma_request_enable_req, single_dma_req;
    logic [4:0]  positive_input_select, negative_input_select;
    logic [31:0] reg_addr, reg_wdata, reg_rdata, q, a, seed = 32'h56dae5c4;
    int          err_total = 0, checks_done = 0, seq_n = 0, cnv_n = 0, rs_n = 0;
    adcctl_top adcctl_top_inst (.*);
    adcctl_host adcctl_host_inst (.*);
    ////////
    // clock, and one-cycle pulses counted as they pass
    always #20 clock = ~clock;
    always @(posedge clock) begin
        seq_n += int'(sequencer_dma_request_enable_req === 1'b1);
        cnv_n += int'(single_dma_req === 1'b1);
        rs_n += int'(analog_restart === 1'b1);
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // settled word: sign, sample, valid set
    function automatic logic [31:0] word(input logic [15:0] v, input logic old);
        return {{4{v[15]}}, v, 8'h00, 1'b1, old, 2'b00};
    endfunction
    task automatic chk(input string n, input logic [31:0] x, g);
        checks_done++;
        if (g !== x) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic rd(input logic [31:0] ad);
        adcctl_host_inst.xfer(1'b0, ad, 32'h0, q, e);
    endtask
    task automatic wr(input logic [31:0] ad, d);
        adcctl_host_inst.xfer(1'b1, ad, d, q, e);
    endtask
    task automatic test_done(input int hang);
        err_total += hang;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clock);
        #1 nrst = 1'b1;
        // reset values
        rd(ADCCTL_CONFIG_ADDR);
        chk("config", 32'h0280, q);
        rd(ADCCTL_CHSEL_ADDR);
        chk("chsel", 32'h111f, q);
        chk("pup_out", 32'h1, 32'(converter_power_on));
        chk("refb_out", 32'h1, 32'(ref_buffer_power_on));
        chk("idle_out", 32'h1, 32'(trig_idle));
        $display("reset test done");
        // every type code with restart and both dma enables; 5 to 7 decode idle
        for (int c = 0; c < 8; c++) begin
            wr(ADCCTL_CONFIG_ADDR, 32'h02d8 | 32'(c));
            a = 32'({trig_logic_array, trig_continuous, trig_single, trig_pin, trig_idle});
            chk("trig", c > 4 ? 32'h1 : 32'h1 << c, a);
        end
        rd(ADCCTL_CONFIG_ADDR);
        chk("config_rw", 32'h029f, q);
        $display("type test done");
        // sequencer runs need the continuous type, so software selects it first
        wr(ADCCTL_CONFIG_ADDR, 32'h029b);
        chk("cont_type", 32'h1, 32'(trig_continuous));
        // random samples, read at c1 and c3 (blanked), c5 and c7; dma off from the 7th
        for (int i = 0; i < 8; i++) begin
            if (i == 6) wr(ADCCTL_CONFIG_ADDR, 32'h0280);
            q = rnd();
            @(posedge clock) #1;
            {sample_done, sample_from_seq, sample_value} = {1'b1, i[0], q[31:16]};
            sample_channel = 5'(q[7:0] % 8'd28);
            a = ADCCTL_RESULT_BASE + {25'h0, sample_channel, 2'b00};
            fork #40 sample_done = 1'b0; join_none
            for (int k = 0; k < 4; k++) begin
                rd(a);
                chk("result", k < 2 ? 32'h0 : word(sample_value, k == 3), q);
            end
        end
        chk("sequencer_dma_request_enable", 32'h3, 32'(seq_n));
        chk("single_dma_request_enable", 32'h3, 32'(cnv_n));
        chk("restarts", 32'h8, 32'(rs_n));
        $display("sample test done");
        // channel select, unmapped place, soft reset
        q = rnd();
        a = {19'h0, 5'(q[15:8] % 8'd20), 3'h0, q[4:0]};
        wr(ADCCTL_CHSEL_ADDR, a);
        rd(ADCCTL_CHSEL_ADDR);
        chk("chsel_rw", a, q);
        chk("sel_out", a, 32'({negative_input_select, 3'h0, positive_input_select}));
        rd(32'h4008_6084);
        chk("unmapped", 32'h1, 32'(e));
        wr(ADCCTL_CONFIG_ADDR, 32'h0400);
        rd(ADCCTL_CONFIG_ADDR);
        chk("soft_reset", 32'h0280, q);
        rd(ADCCTL_CHSEL_ADDR);
        chk("soft_reset_sel", 32'h111f, q);
        chk("refb_after", 32'h1, 32'(ref_buffer_power_on));
        $display("register test done");
        test_done(0);
    end
endmodule
`default_nettype wire
